// >>> common/thr_cfg_pkg.sv
package thr_cfg_pkg;

  // register offsets on the serial register port
  localparam logic [3:0] OFS_SENSOR_TWO = 4'h3;
  localparam logic [3:0] OFS_X_THR      = 4'h4;
  localparam logic [3:0] OFS_Y_THR      = 4'h5;
  localparam logic [3:0] OFS_Z_THR      = 4'h6;
  localparam logic [3:0] OFS_TEMP       = 4'h7;
  localparam logic [3:0] OFS_INT_ONE    = 4'h8;

  localparam logic [7:0] RESET_VALUE    = 8'h00;
  localparam logic [7:0] MASK_SENSOR    = 8'h7f;
  localparam logic [7:0] MASK_INT_ONE   = 8'he0;

  // sensor_setup_two fields
  localparam int BIT_CROSS_COUNT = 6;
  localparam int BIT_DIRECTION   = 5;
  localparam int BIT_GAIN_CH     = 4;
  localparam int BIT_ANGLE_HI    = 3;
  localparam int BIT_ANGLE_LO    = 2;
  localparam int BIT_XY_RANGE    = 1;
  localparam int BIT_Z_RANGE     = 0;
  // temperature_setup and interrupt_setup_one fields
  localparam int BIT_TEMP_ON     = 0;
  localparam int BIT_RESULT_IRQ  = 7;
  localparam int BIT_LIMIT_IRQ   = 6;
  localparam int BIT_PULSE_MODE  = 5;

  localparam logic [2:0] COUNT_ONE  = 3'h1;
  localparam logic [2:0] COUNT_FOUR = 3'h4;

  localparam logic [2:0] HYST_SINGLE = 3'h0;
  localparam logic [2:0] HYST_PAIR   = 3'h1;
  localparam logic [2:0] HYST_BAND0  = 3'h2;
  localparam logic [17:0] BAND_HALF0 = 18'h00040;

  localparam logic [2:0] ROUTE_PIN      = 3'h1;
  localparam logic [2:0] ROUTE_PIN_IDLE = 3'h2;
  localparam logic [2:0] ROUTE_SCL      = 3'h3;
  localparam logic [2:0] ROUTE_SCL_IDLE = 3'h4;
  localparam logic [2:0] ROUTE_UNIPOLAR = 3'h5;
  localparam logic [2:0] ROUTE_OMNI     = 3'h6;

  localparam logic [1:0] CH_NONE = 2'h0;
  localparam logic [1:0] CH_X    = 2'h1;
  localparam logic [1:0] CH_Y    = 2'h2;
  localparam logic [1:0] CH_Z    = 2'h3;

  localparam int CLK_PERIOD_NS = 8;
  localparam int PULSE_NS      = 10000;
  localparam logic [10:0] PULSE_CYC = 11'(PULSE_NS / CLK_PERIOD_NS);

  typedef struct packed {
    logic       wr;
    logic [3:0] addr;
    logic [7:0] data;
  } reg_req_t;

  typedef struct packed {
    logic [15:0] x;
    logic [15:0] y;
    logic [15:0] z;
  } field_t;

  typedef enum logic [1:0] {LK_IDLE = 2'b01, LK_WAIT = 2'b10} link_state_t;

endpackage

// >>> hw/threshold_interrupt_config.sv
// Summary of operation
// - interrupt fires after one crossing, or four when the count bit is set
// - direction bit picks above or below; ignored when band select exceeds one
// - gain channel bit sends gain value to first or second channel of pair
// - angle field: off, X then Y, Y then Z, X then Z
// - X/Y range bit selects lower or doubled range, lower after reset
// - Z range bit selects lower or doubled range for Z axis
// - X threshold is signed 8-bit code; zero disables X check
// - threshold step tracks selected range, full scale code 128
// - Y threshold is signed 8-bit code; zero disables Y check
// - Z threshold is signed 8-bit code scaled by Z range; zero disables
// - temperature limit is 7-bit code, 8 C per step, zero disables
// - temperature channel bit adds temperature to the conversion set
// - result interrupt enable raises interrupt when conversions complete
// - limit interrupt enable raises interrupt on configured crossing
// - latched interrupt holds until primary addresses device; else 10 us pulse
// - band select 0 signed threshold, 1 symmetric pair, higher values bands
// - route mode sends interrupt to pin or clock line, or runs a switch
module threshold_interrupt_config (
  input  wire logic                   clk,
  input  wire logic                   sys_rst,
  input  wire logic                   ce,
  input  wire logic                   link_clk,
  input  wire logic                   req_valid,
  input  wire thr_cfg_pkg::reg_req_t  req,
  output logic                        req_ready,
  output logic                        rsp_valid,
  output logic [7:0]                  rsp_data,
  input  wire logic                   dev_addressed,
  input  wire logic                   bus_busy,
  input  wire logic [2:0]             hysteresis_band_select,
  input  wire logic [2:0]             int_route_mode,
  input  wire logic                   meas_valid,
  input  wire thr_cfg_pkg::field_t    meas,
  input  wire logic [6:0]             temp_code,
  input  wire logic                   conv_done,
  output logic                        xy_range_high,
  output logic                        z_range_high,
  output logic [1:0]                  angle_first,
  output logic [1:0]                  angle_second,
  output logic [1:0]                  gain_target,
  output logic                        temperature_channel_on,
  output logic                        irq_pin,
  output logic                        irq_scl,
  output logic                        switch_out
);

  typedef struct packed {
    logic [7:0]  sensor_setup_two;
    logic [7:0]  x_axis_threshold;
    logic [7:0]  y_axis_threshold;
    logic [7:0]  z_axis_threshold;
    logic [7:0]  temperature_setup;
    logic [7:0]  interrupt_setup_one;
    logic [2:0]  req_s;
    logic        req_seen;
    logic [2:0]  addr_s;
    logic        addr_seen;
    logic [2:0]  busy_s;
    logic        busy_q;
    logic        ack_tgl;
    logic [7:0]  rdata;
    logic [3:0]  above;
    logic [2:0]  cross_cnt;
    logic        irq_lat;
    logic [10:0] pulse_cnt;
    logic        irq_pin;
    logic        irq_scl;
    logic        switch_out;
    logic [1:0]  ang_first;
    logic [1:0]  ang_second;
    logic [1:0]  gain_target;
    logic        xy_range;
    logic        z_range;
    logic        temp_on;
  } core_t;

  typedef struct packed {
    thr_cfg_pkg::link_state_t state;
    thr_cfg_pkg::reg_req_t    req_hold;
    logic                     req_tgl;
    logic                     addr_tgl;
    logic                     busy_q;
    logic [2:0]               ack_s;
    logic                     ack_seen;
    logic                     rsp_valid;
    logic [7:0]               rsp_data;
  } link_t;

  core_t c_r;
  core_t c_nxt;
  link_t l_r;
  link_t l_nxt;
  logic  req_evt;
  logic  addr_evt;
  logic  any_evt;
  logic  thr_evt;
  logic  irq_evt;
  logic  irq_active;

  // a change counts only once the second and third stages agree
  function automatic logic sync_event(input logic [2:0] s, input logic seen);
    return (s[1] == s[2]) && (s[2] != seen);
  endfunction

  function automatic logic [3:0] angle_pair(input logic [1:0] sel);
    unique case (sel)
      2'h1:    return {thr_cfg_pkg::CH_X, thr_cfg_pkg::CH_Y};
      2'h2:    return {thr_cfg_pkg::CH_Y, thr_cfg_pkg::CH_Z};
      2'h3:    return {thr_cfg_pkg::CH_X, thr_cfg_pkg::CH_Z};
      default: return {thr_cfg_pkg::CH_NONE, thr_cfg_pkg::CH_NONE};
    endcase
  endfunction

  // field codes are normalised to the selected range, so code<<8 tracks the range step
  function automatic logic thr_check(input logic [15:0] f, input logic [7:0] code, input logic [2:0] hyst,
                                     input logic dir, input logic prev);
    logic signed [17:0] fv;
    logic signed [17:0] tv;
    logic signed [17:0] mag;
    logic signed [17:0] half;
    logic               hit;
    fv   = {{2{f[15]}}, f};
    tv   = {{2{code[7]}}, code, 8'h00};
    mag  = fv[17] ? -fv : fv;
    half = thr_cfg_pkg::BAND_HALF0 << (hyst - thr_cfg_pkg::HYST_BAND0);
    if (code == 8'h00) begin
      hit = 1'h0;
    end else if (hyst == thr_cfg_pkg::HYST_SINGLE) begin
      hit = dir ? (fv < tv) : (fv > tv);
    end else if (hyst == thr_cfg_pkg::HYST_PAIR) begin
      tv  = {3'h0, code[6:0], 8'h00};
      hit = dir ? (mag < tv) : (mag > tv);
    end else begin
      // direction is ignored here; band edges give hysteresis around the code
      hit = prev ? (fv > tv - half) : (fv > tv + half);
    end
    return hit;
  endfunction

  always_comb begin
    logic [7:0]  sel_code;
    logic [15:0] sel_f;
    logic [15:0] abs_f;
    logic [3:0]  pair;
    logic        pulse_mode;
    c_nxt      = c_r;
    sel_code   = 8'h00;
    sel_f      = 16'h0000;
    abs_f      = 16'h0000;
    pair       = angle_pair(c_r.sensor_setup_two[thr_cfg_pkg::BIT_ANGLE_HI:thr_cfg_pkg::BIT_ANGLE_LO]);
    pulse_mode = c_r.interrupt_setup_one[thr_cfg_pkg::BIT_PULSE_MODE];
    any_evt    = 1'h0;
    thr_evt    = 1'h0;

    c_nxt.req_s  = {c_r.req_s[1:0], l_r.req_tgl};
    c_nxt.addr_s = {c_r.addr_s[1:0], l_r.addr_tgl};
    c_nxt.busy_s = {c_r.busy_s[1:0], l_r.busy_q};
    req_evt      = sync_event(c_r.req_s, c_r.req_seen);
    addr_evt     = sync_event(c_r.addr_s, c_r.addr_seen);
    if (req_evt) begin
      c_nxt.req_seen = c_r.req_s[2];
    end
    if (addr_evt) begin
      c_nxt.addr_seen = c_r.addr_s[2];
    end
    if (c_r.busy_s[1] == c_r.busy_s[2]) begin
      c_nxt.busy_q = c_r.busy_s[2];
    end

    // request fields stay stable in the link domain until the ack toggle returns
    if (req_evt) begin
      unique case (l_r.req_hold.addr)
        thr_cfg_pkg::OFS_SENSOR_TWO: c_nxt.rdata = c_r.sensor_setup_two;
        thr_cfg_pkg::OFS_X_THR:      c_nxt.rdata = c_r.x_axis_threshold;
        thr_cfg_pkg::OFS_Y_THR:      c_nxt.rdata = c_r.y_axis_threshold;
        thr_cfg_pkg::OFS_Z_THR:      c_nxt.rdata = c_r.z_axis_threshold;
        thr_cfg_pkg::OFS_TEMP:       c_nxt.rdata = c_r.temperature_setup;
        thr_cfg_pkg::OFS_INT_ONE:    c_nxt.rdata = c_r.interrupt_setup_one;
        default:                     c_nxt.rdata = 8'h00;
      endcase
      if (l_r.req_hold.wr) begin
        unique case (l_r.req_hold.addr)
          thr_cfg_pkg::OFS_SENSOR_TWO: c_nxt.sensor_setup_two    = l_r.req_hold.data & thr_cfg_pkg::MASK_SENSOR;
          thr_cfg_pkg::OFS_X_THR:      c_nxt.x_axis_threshold    = l_r.req_hold.data;
          thr_cfg_pkg::OFS_Y_THR:      c_nxt.y_axis_threshold    = l_r.req_hold.data;
          thr_cfg_pkg::OFS_Z_THR:      c_nxt.z_axis_threshold    = l_r.req_hold.data;
          thr_cfg_pkg::OFS_TEMP:       c_nxt.temperature_setup   = l_r.req_hold.data;
          thr_cfg_pkg::OFS_INT_ONE:    c_nxt.interrupt_setup_one = l_r.req_hold.data & thr_cfg_pkg::MASK_INT_ONE;
          default:                     c_nxt.rdata = 8'h00;
        endcase
      end
      c_nxt.ack_tgl = ~c_r.ack_tgl;
    end

    if (meas_valid) begin
      c_nxt.above[0] = thr_check(meas.x, c_r.x_axis_threshold, hysteresis_band_select,
                                 c_r.sensor_setup_two[thr_cfg_pkg::BIT_DIRECTION], c_r.above[0]);
      c_nxt.above[1] = thr_check(meas.y, c_r.y_axis_threshold, hysteresis_band_select,
                                 c_r.sensor_setup_two[thr_cfg_pkg::BIT_DIRECTION], c_r.above[1]);
      c_nxt.above[2] = thr_check(meas.z, c_r.z_axis_threshold, hysteresis_band_select,
                                 c_r.sensor_setup_two[thr_cfg_pkg::BIT_DIRECTION], c_r.above[2]);
      c_nxt.above[3] = c_r.temperature_setup[thr_cfg_pkg::BIT_TEMP_ON] && (c_r.temperature_setup[7:1] != 7'h00)
                       && (temp_code > c_r.temperature_setup[7:1]);
      any_evt = |(c_nxt.above & ~c_r.above);
    end

    if (any_evt) begin
      if ((c_r.cross_cnt + 3'h1) >= (c_r.sensor_setup_two[thr_cfg_pkg::BIT_CROSS_COUNT] ?
                                     thr_cfg_pkg::COUNT_FOUR : thr_cfg_pkg::COUNT_ONE)) begin
        thr_evt         = 1'h1;
        c_nxt.cross_cnt = 3'h0;
      end else begin
        c_nxt.cross_cnt = c_r.cross_cnt + 3'h1;
      end
    end

    // switch modes take over the output entirely
    irq_evt = ((thr_evt && c_r.interrupt_setup_one[thr_cfg_pkg::BIT_LIMIT_IRQ])
              || (conv_done && c_r.interrupt_setup_one[thr_cfg_pkg::BIT_RESULT_IRQ]))
              && (int_route_mode != thr_cfg_pkg::ROUTE_UNIPOLAR) && (int_route_mode != thr_cfg_pkg::ROUTE_OMNI);
    if (irq_evt && !pulse_mode) begin
      c_nxt.irq_lat = 1'h1;
    end else if (addr_evt || pulse_mode) begin
      c_nxt.irq_lat = 1'h0;
    end
    if (irq_evt && pulse_mode) begin
      c_nxt.pulse_cnt = thr_cfg_pkg::PULSE_CYC;
    end else if (c_r.pulse_cnt != 11'h000) begin
      c_nxt.pulse_cnt = c_r.pulse_cnt - 11'h001;
    end
    irq_active = c_nxt.irq_lat || (c_nxt.pulse_cnt != 11'h000);

    if (c_r.x_axis_threshold != 8'h00) begin
      sel_code = c_r.x_axis_threshold;
      sel_f    = meas.x;
    end else if (c_r.y_axis_threshold != 8'h00) begin
      sel_code = c_r.y_axis_threshold;
      sel_f    = meas.y;
    end else begin
      sel_code = c_r.z_axis_threshold;
      sel_f    = meas.z;
    end
    abs_f = sel_f[15] ? ((sel_f == 16'h8000) ? 16'h7fff : 16'(-sel_f)) : sel_f;

    c_nxt.irq_pin = irq_active && ((int_route_mode == thr_cfg_pkg::ROUTE_PIN)
                    || ((int_route_mode == thr_cfg_pkg::ROUTE_PIN_IDLE) && !c_r.busy_q));
    c_nxt.irq_scl = irq_active && ((int_route_mode == thr_cfg_pkg::ROUTE_SCL)
                    || ((int_route_mode == thr_cfg_pkg::ROUTE_SCL_IDLE) && !c_r.busy_q));
    if (int_route_mode == thr_cfg_pkg::ROUTE_UNIPOLAR && meas_valid) begin
      c_nxt.switch_out = thr_check(sel_f, sel_code, hysteresis_band_select, 1'h0, c_r.switch_out);
    end else if (int_route_mode == thr_cfg_pkg::ROUTE_OMNI && meas_valid) begin
      c_nxt.switch_out = thr_check(abs_f, sel_code, hysteresis_band_select, 1'h0, c_r.switch_out);
    end else if (int_route_mode != thr_cfg_pkg::ROUTE_UNIPOLAR && int_route_mode != thr_cfg_pkg::ROUTE_OMNI) begin
      c_nxt.switch_out = 1'h0;
    end

    c_nxt.ang_first   = pair[3:2];
    c_nxt.ang_second  = pair[1:0];
    c_nxt.gain_target = c_r.sensor_setup_two[thr_cfg_pkg::BIT_GAIN_CH] ? pair[1:0] : pair[3:2];
    c_nxt.xy_range    = c_r.sensor_setup_two[thr_cfg_pkg::BIT_XY_RANGE];
    c_nxt.z_range     = c_r.sensor_setup_two[thr_cfg_pkg::BIT_Z_RANGE];
    c_nxt.temp_on     = c_r.temperature_setup[thr_cfg_pkg::BIT_TEMP_ON];
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      c_r <= '0;
    end else if (ce) begin
      c_r <= c_nxt;
    end
  end

  // link side: one request in flight, answered after the ack toggle crosses back
  always_comb begin
    l_nxt           = l_r;
    l_nxt.rsp_valid = 1'h0;
    l_nxt.ack_s     = {l_r.ack_s[1:0], c_r.ack_tgl};
    l_nxt.busy_q    = bus_busy;
    if (dev_addressed) begin
      l_nxt.addr_tgl = ~l_r.addr_tgl;
    end
    unique case (l_r.state)
      thr_cfg_pkg::LK_IDLE: begin
        if (req_valid) begin
          l_nxt.req_hold = req;
          l_nxt.req_tgl  = ~l_r.req_tgl;
          l_nxt.state    = thr_cfg_pkg::LK_WAIT;
        end
      end
      thr_cfg_pkg::LK_WAIT: begin
        if (sync_event(l_r.ack_s, l_r.ack_seen)) begin
          l_nxt.ack_seen  = l_r.ack_s[2];
          l_nxt.rsp_data  = c_r.rdata;
          l_nxt.rsp_valid = 1'h1;
          l_nxt.state     = thr_cfg_pkg::LK_IDLE;
        end
      end
      default: l_nxt.state = thr_cfg_pkg::LK_IDLE;
    endcase
  end

  always_ff @(posedge link_clk or posedge sys_rst) begin
    if (sys_rst) begin
      l_r       <= '0;
      l_r.state <= thr_cfg_pkg::LK_IDLE;
    end else begin
      l_r <= l_nxt;
    end
  end

  assign req_ready              = l_r.state[0];
  assign rsp_valid              = l_r.rsp_valid;
  assign rsp_data               = l_r.rsp_data;
  assign xy_range_high          = c_r.xy_range;
  assign z_range_high           = c_r.z_range;
  assign angle_first            = c_r.ang_first;
  assign angle_second           = c_r.ang_second;
  assign gain_target            = c_r.gain_target;
  assign temperature_channel_on = c_r.temp_on;
  assign irq_pin                = c_r.irq_pin;
  assign irq_scl                = c_r.irq_scl;
  assign switch_out             = c_r.switch_out;

  single_count_a: assert property (@(posedge clk) disable iff (sys_rst)
    ce && any_evt && !c_r.sensor_setup_two[thr_cfg_pkg::BIT_CROSS_COUNT] |-> thr_evt && c_nxt.cross_cnt == 3'h0)
    else $error("single crossing did not fire");
  four_count_a: assert property (@(posedge clk) disable iff (sys_rst)
    thr_evt && c_r.sensor_setup_two[thr_cfg_pkg::BIT_CROSS_COUNT] |-> c_r.cross_cnt == 3'h3)
    else $error("fourth crossing count wrong");
  above_check_a: assert property (@(posedge clk) disable iff (sys_rst)
    ce && meas_valid && hysteresis_band_select == 3'h0 && !c_r.sensor_setup_two[thr_cfg_pkg::BIT_DIRECTION]
    && c_r.x_axis_threshold != 8'h00 && $signed(meas.x) > $signed({c_r.x_axis_threshold, 8'h00})
    |=> c_r.above[0])
    else $error("field above threshold not flagged");
  zero_disable_a: assert property (@(posedge clk) disable iff (sys_rst)
    ce && meas_valid && c_r.x_axis_threshold == 8'h00 |=> !c_r.above[0])
    else $error("zero threshold still compared");
  angle_pair_a: assert property (@(posedge clk) disable iff (sys_rst)
    ce && c_r.sensor_setup_two[3:2] == 2'h2 |=> angle_first == thr_cfg_pkg::CH_Y && angle_second == thr_cfg_pkg::CH_Z)
    else $error("angle pair decode wrong");
  gain_route_a: assert property (@(posedge clk) disable iff (sys_rst)
    ce && c_r.sensor_setup_two[3:2] == 2'h3 && c_r.sensor_setup_two[thr_cfg_pkg::BIT_GAIN_CH]
    |=> gain_target == thr_cfg_pkg::CH_Z)
    else $error("gain channel routed wrong");
  range_follow_a: assert property (@(posedge clk) disable iff (sys_rst)
    ce |=> xy_range_high == $past(c_r.sensor_setup_two[1]) && z_range_high == $past(c_r.sensor_setup_two[0]))
    else $error("range outputs lag register");
  result_latch_a: assert property (@(posedge clk) disable iff (sys_rst)
    ce && irq_evt && !c_r.interrupt_setup_one[thr_cfg_pkg::BIT_PULSE_MODE] ##1 ce && !addr_evt |=> c_r.irq_lat)
    else $error("latched interrupt not held");
  pulse_load_a: assert property (@(posedge clk) disable iff (sys_rst)
    ce && irq_evt && c_r.interrupt_setup_one[thr_cfg_pkg::BIT_PULSE_MODE] |=> c_r.pulse_cnt == thr_cfg_pkg::PULSE_CYC)
    else $error("pulse length not loaded");
  latch_clear_a: assert property (@(posedge clk) disable iff (sys_rst)
    ce && addr_evt && !irq_evt |=> !c_r.irq_lat)
    else $error("addressing did not clear interrupt");
  irq_off_a: assert property (@(posedge clk) disable iff (sys_rst)
    ce && c_r.interrupt_setup_one[7:6] == 2'h0 && !c_r.irq_lat && c_r.pulse_cnt == 11'h000 |=> !c_r.irq_lat)
    else $error("interrupt raised while disabled");
  reserved_zero_a: assert property (@(posedge clk) disable iff (sys_rst)
    !c_r.sensor_setup_two[7] && c_r.interrupt_setup_one[4:0] == 5'h00)
    else $error("reserved bit stored");
  busy_gate_a: assert property (@(posedge clk) disable iff (sys_rst)
    ce && int_route_mode == thr_cfg_pkg::ROUTE_PIN_IDLE && c_r.busy_q |=> !irq_pin)
    else $error("interrupt driven while bus busy");

endmodule

// >>> tb/reg_primary.sv
module reg_primary (
  input  wire logic             link_clk,
  input  wire logic             req_ready,
  input  wire logic             rsp_valid,
  input  wire logic [7:0]       rsp_data,
  output logic                  req_valid,
  output thr_cfg_pkg::reg_req_t req,
  output logic                  dev_addressed
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    req_valid = 1'b0;
    req = '0;
    dev_addressed = 1'b0;
  end
  // one byte in flight; q stays unknown if the port never answers
  task automatic xfer(input logic wr, input logic [3:0] a, input logic [7:0] d, output logic [7:0] q);
    int n;
    n = 0;
    q = 8'hxx;
    @(negedge link_clk);
    req_valid <= 1'b1;
    req <= '{wr, a, d};
    do @(posedge link_clk); while (req_ready !== 1'b1 && n++ < 50);
    @(negedge link_clk);
    req_valid <= 1'b0;
    req <= ~req; // released lines must not keep the old value
    while (rsp_valid !== 1'b1 && n++ < 100) @(negedge link_clk);
    if (rsp_valid === 1'b1) q = rsp_data;
  endtask
  task automatic address();
    @(negedge link_clk);
    dev_addressed <= 1'b1;
    @(negedge link_clk);
    dev_addressed <= 1'b0;
  endtask
endmodule

// >>> tb/threshold_interrupt_config_tb_top.sv
module threshold_interrupt_config_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, link_clk = 1'b0, sys_rst = 1'b1, req_valid, req_ready, rsp_valid, dev_addressed;
  logic meas_valid = 1'b0, conv_done = 1'b0, xy_range_high, z_range_high, temperature_channel_on;
  logic irq_pin, irq_scl, switch_out;
  logic [2:0] hyst = 3'h0;
  logic [2:0] route = 3'h1;
  logic ce = 1'b1, busy = 1'b0;
  logic [1:0] angle_first, angle_second, gain_target;
  logic [6:0] temp_code = 7'h00;
  logic [7:0] rsp_data, q;
  thr_cfg_pkg::reg_req_t req;
  thr_cfg_pkg::field_t   meas = '0;
  int n_fail = 0, samples_checked = 0, cycles = 0, k;
  logic [7:0] msk [6] = '{8'h7f, 8'hff, 8'hff, 8'hff, 8'hff, 8'he0};
  logic [1:0] f1 [4] = '{2'h0, 2'h1, 2'h2, 2'h1};
  logic [1:0] f2 [4] = '{2'h0, 2'h2, 2'h3, 2'h3};
  initial forever #4 clk = ~clk;
  initial begin
    #1.3;
    forever #6 link_clk = ~link_clk;
  end
  threshold_interrupt_config threshold_interrupt_config_inst (
    .clk(clk), .sys_rst(sys_rst), .ce(ce), .link_clk(link_clk), .req_valid(req_valid), .req(req),
    .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .dev_addressed(dev_addressed),
    .bus_busy(busy), .hysteresis_band_select(hyst), .int_route_mode(route), .meas_valid(meas_valid),
    .meas(meas), .temp_code(temp_code), .conv_done(conv_done), .xy_range_high(xy_range_high),
    .z_range_high(z_range_high), .angle_first(angle_first), .angle_second(angle_second),
    .gain_target(gain_target), .temperature_channel_on(temperature_channel_on), .irq_pin(irq_pin),
    .irq_scl(irq_scl), .switch_out(switch_out));
  reg_primary reg_primary_inst (
    .link_clk(link_clk), .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
    .req_valid(req_valid), .req(req), .dev_addressed(dev_addressed));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    reg_primary_inst.xfer(1'b1, a, d, q);
  endtask
  task automatic pulse_in(input logic [15:0] x, input logic done);
    @(negedge clk);
    meas.x <= x;
    meas_valid <= ~done;
    conv_done <= done;
    @(negedge clk);
    meas_valid <= 1'b0;
    conv_done <= 1'b0;
    repeat (3) @(negedge clk);
  endtask
  task automatic clr();
    reg_primary_inst.address();
    repeat (12) @(negedge clk);
  endtask
  task automatic t_regs();
    for (k = 0; k < 6; k++) begin
      reg_primary_inst.xfer(1'b0, 4'(k + 3), 8'h00, q);
      chk(q, 8'h00);
      wr(4'(k + 3), 8'hff);
      reg_primary_inst.xfer(1'b0, 4'(k + 3), 8'h00, q);
      chk(q, msk[k]);
      wr(4'(k + 3), 8'h00);
    end
    wr(4'h2, 8'h5a);
    reg_primary_inst.xfer(1'b0, 4'h2, 8'h00, q);
    chk(q, 8'h00);
  endtask
  task automatic t_decode();
    for (k = 0; k < 8; k++) begin
      wr(thr_cfg_pkg::OFS_SENSOR_TWO, {3'h0, k[2], k[1:0], k[0], k[1]});
      chk({angle_first, angle_second}, {f1[k[1:0]], f2[k[1:0]]});
      if (k[1:0] != 0) chk(gain_target, k[2] ? f2[k[1:0]] : f1[k[1:0]]);
      chk({xy_range_high, z_range_high}, {k[0], k[1]});
    end
    wr(thr_cfg_pkg::OFS_TEMP, 8'h01);
    chk(temperature_channel_on, 1'b1);
    wr(thr_cfg_pkg::OFS_TEMP, 8'h00);
    chk(temperature_channel_on, 1'b0);
  endtask
  task automatic t_done();
    wr(thr_cfg_pkg::OFS_INT_ONE, 8'h80);
    pulse_in(16'h0000, 1'b1);
    chk(irq_pin, 1'b1);
    repeat (40) @(negedge clk);
    chk(irq_pin, 1'b1);
    clr();
    chk(irq_pin, 1'b0);
    wr(thr_cfg_pkg::OFS_INT_ONE, 8'h00);
    pulse_in(16'h0000, 1'b1);
    chk(irq_pin, 1'b0);
    wr(thr_cfg_pkg::OFS_INT_ONE, 8'ha0);
    pulse_in(16'h0000, 1'b1);
    for (k = 3; irq_pin === 1'b1 && k < 2000; k++) @(negedge clk);
    chk(16'(k), {5'h0, thr_cfg_pkg::PULSE_CYC});
  endtask
  task automatic t_cross();
    wr(thr_cfg_pkg::OFS_INT_ONE, 8'h40);
    pulse_in(16'h2000, 1'b0);
    chk(irq_pin, 1'b0);
    wr(thr_cfg_pkg::OFS_X_THR, 8'h10);
    pulse_in(16'h0000, 1'b0);
    pulse_in(16'h2000, 1'b0);
    chk(irq_pin, 1'b1);
    clr();
    wr(thr_cfg_pkg::OFS_SENSOR_TWO, 8'h40);
    for (k = 0; k < 4; k++) begin
      chk(irq_pin, 1'b0);
      pulse_in(16'h0000, 1'b0);
      pulse_in(16'h2000, 1'b0);
    end
    chk(irq_pin, 1'b1);
    clr();
    wr(thr_cfg_pkg::OFS_SENSOR_TWO, 8'h20);
    pulse_in(16'h2000, 1'b0);
    chk(irq_pin, 1'b0);
    pulse_in(16'h0000, 1'b0);
    chk(irq_pin, 1'b1);
    clr();
    hyst <= thr_cfg_pkg::HYST_BAND0;
    // the flag is still set from the low field; drop it below the lower band edge first
    pulse_in(16'h0000, 1'b0);
    chk(irq_pin, 1'b0);
    pulse_in(16'h2000, 1'b0);
    chk(irq_pin, 1'b1);
  endtask
  task automatic t_route();
    clr();
    route <= thr_cfg_pkg::ROUTE_SCL;
    wr(thr_cfg_pkg::OFS_INT_ONE, 8'h80);
    pulse_in(16'h0000, 1'b1);
    chk({irq_pin, irq_scl}, 2'h1);
    clr();
    chk(irq_scl, 1'b0);
    route <= thr_cfg_pkg::ROUTE_PIN_IDLE;
    busy <= 1'b1;
    repeat (10) @(negedge clk);
    pulse_in(16'h0000, 1'b1);
    chk({irq_pin, irq_scl}, 2'h0);
    busy <= 1'b0;
    repeat (10) @(negedge clk);
    chk(irq_pin, 1'b1);
    clr();
    route <= thr_cfg_pkg::ROUTE_UNIPOLAR;
    pulse_in(16'h2000, 1'b0);
    chk({irq_pin, switch_out}, 2'h1);
    pulse_in(16'he000, 1'b0);
    chk(switch_out, 1'b0);
    route <= thr_cfg_pkg::ROUTE_OMNI;
    pulse_in(16'he000, 1'b0);
    chk(switch_out, 1'b1);
    route <= thr_cfg_pkg::ROUTE_PIN;
    repeat (2) @(negedge clk);
    chk(switch_out, 1'b0);
  endtask
  task automatic t_temp();
    ce <= 1'b0;
    pulse_in(16'h0000, 1'b1);
    ce <= 1'b1;
    chk(irq_pin, 1'b0);
    wr(thr_cfg_pkg::OFS_X_THR, 8'h00);
    wr(thr_cfg_pkg::OFS_INT_ONE, 8'h40);
    wr(thr_cfg_pkg::OFS_TEMP, 8'h35);
    @(negedge clk);
    temp_code <= 7'h1a;
    pulse_in(16'h0000, 1'b0);
    chk(irq_pin, 1'b0);
    temp_code <= 7'h1b;
    pulse_in(16'h0000, 1'b0);
    chk(irq_pin, 1'b1);
  endtask
  task automatic conclude();
    $display("checks %0d failures %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // generous ceiling; the full sequence needs well under a third of it
  always @(posedge clk) begin
    cycles++;
    if (cycles == 60000) begin
      n_fail++;
      conclude();
    end
  end
  initial begin
    repeat (4) @(negedge clk);
    sys_rst = 1'b0;
    t_regs();
    t_decode();
    t_done();
    t_cross();
    t_route();
    t_temp();
    conclude();
  end
endmodule
